// *** pkg/adc_ctrl_pkg.sv ***
// Constants, field positions and state type for the control-byte decoder
package adc_ctrl_pkg;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_IN_BYTE = 4'h8;
  localparam logic [3:0] TRACK_AFTER_BITS = 4'h6;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam int POS_SEL_MSB = 6;
  localparam int POS_SEL_MID = 5;
  localparam int POS_SEL_LSB = 4;
  localparam int POS_POLARITY = 3;
  localparam int POS_INPUT_CFG = 2;
  localparam int POS_POWER = 1;
  localparam int POS_CLK_SRC = 0;
  localparam logic [2:0] CH_WIDTH_ZERO = 3'h0;
  localparam logic [3:0] NEG_IS_COM = 4'h8;
  localparam logic [2:0] RESET_CFG = 3'h0;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_HOLD = 2'b10,
    ST_CONV = 2'b11
  } dec_state_t;
endpackage

// *** hdl/edge_sync.sv ***
// Two-flop synchroniser for one external level, with edge flags
`timescale 1ns/1ps
module edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // First flop feeds only the second one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges seen on the settled copy only
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule

// *** hdl/adc_control_byte_decoder.sv ***
// Control-byte decoder and track/hold sequencer of a serial 8-bit ADC
`timescale 1ns/1ps
// Operation
// RULE_01: With select low, the first 1 on data in is the start bit.
// RULE_02: Bits 6,5,4 form the three-bit channel select, MSB first.
// RULE_03: Bit 3 picks polarity: 1 unipolar, 0 bipolar.
// RULE_04: Bit 2 picks input config: 1 single-ended, 0 differential.
// RULE_05: Bit 1 picks power: 1 fully operational, 0 power-down.
// RULE_06: Bit 0 picks conversion clock: 1 external serial, 0 internal.
// RULE_07: Track begins on the falling clock edge after the sixth bit.
// RULE_08: Hold begins on the falling clock edge after the eighth bit.
// RULE_09: Negative node goes to common in single-ended, pair partner in differential.
// RULE_10: After conversion the hold capacitor returns to the positive input.
// RULE_11: Eight-input single-ended codes 000,100,001,...,111 pick channels 0 to 7.
// RULE_12: Eight-input differential: codes 0xx even channel positive, 1xx odd positive.
// RULE_13: Four inputs ignore select LSB; same pattern over channels 0 to 3.
// RULE_14: Differential unipolar with negative difference gives invalid code zero.
// RULE_15: Host sends a fresh control byte before every conversion.
// RULE_16: Host keeps tracking interval at least the acquisition time, one microsecond.
// RULE_17: Data in is sampled on each rising serial clock while selected.
// RULE_18: Zero bits before the start bit are ignored.
// RULE_19: Conversion begins on the falling clock edge after the eighth bit.
// RULE_20: Unipolar results straight binary, bipolar results two's complement.
// RULE_21: After reset: idle, bit counter clear, no conversion pending.
module adc_control_byte_decoder
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic four_inputs,
  input wire logic conv_done,
  input wire logic conv_result_zero,
  output logic chan_select_msb,
  output logic chan_select_mid,
  output logic chan_select_lsb,
  output logic polarity_select,
  output logic input_config_select,
  output logic power_state_select,
  output logic clock_source_select,
  output logic tracking,
  output logic hold_capacitor,
  output logic conv_start,
  output logic conv_busy,
  output logic twos_complement,
  output logic [2:0] pos_channel,
  output logic [3:0] neg_channel,
  output logic result_invalid
);
  logic cs_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic [BYTE_W-1:0] shift_r;
  logic [3:0] count_r;
  dec_state_t state_r;
  logic [2:0] trk_pos;
  // Fields sit this many places low in the shifter when the sixth bit is in
  localparam int TRACK_LAG = int'(BITS_IN_BYTE) - int'(TRACK_AFTER_BITS);
  logic [2:0] pos_nxt;
  logic [3:0] neg_nxt;

  // Positive input number; same order in both configurations
  function automatic logic [2:0] pos_of(input logic [2:0] sel, input logic four);
    // RULE_11 single-ended order
    // RULE_13 lowest bit ignored
    pos_of = four ? {1'b0, sel[1], sel[2]} : {sel[1], sel[0], sel[2]};
  endfunction

  // Resolves select code into positive and negative input numbers
  function automatic logic [6:0] route_inputs(input logic [2:0] sel, input logic sgl,
                                              input logic four);
    logic [2:0] p;
    logic [3:0] n;
    // RULE_12 pair, sign from msb
    p = pos_of(sel, four);
    n = NEG_IS_COM;
    if (!sgl) begin
      // RULE_09 partner is the other pair member
      n = {1'b0, p[2:1], ~p[0]};
    end
    route_inputs = {p, n};
  endfunction

  // Pins are asynchronous to clk
  edge_sync u_cs (.clk(clk), .rst(rst), .async_in(cs_n), .level(cs_n_s), .rise(), .fall());
  edge_sync u_sclk (.clk(clk), .rst(rst), .async_in(sclk), .level(), .rise(sclk_rise),
                    .fall(sclk_fall));
  edge_sync u_din (.clk(clk), .rst(rst), .async_in(din), .level(din_s), .rise(), .fall());

  // Byte capture and framing state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // RULE_21 idle after reset
      state_r <= ST_IDLE;
      count_r <= CNT_RESET;
      shift_r <= RESET_BYTE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // RULE_17 sample on rise
          // RULE_18 leading zeros ignored
          // RULE_01 first one starts
          if (!cs_n_s && sclk_rise && din_s) begin
            shift_r <= {{(BYTE_W-1){1'b0}}, 1'b1};
            count_r <= 4'h1;
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_n_s) begin
            // Aborted frame, byte dropped
            state_r <= ST_IDLE;
            count_r <= CNT_RESET;
          end else if (sclk_rise && count_r != BITS_IN_BYTE) begin
            shift_r <= {shift_r[BYTE_W-2:0], din_s};
            count_r <= count_r + 4'h1;
          end else if (sclk_fall && count_r == BITS_IN_BYTE) begin
            // RULE_19 start after eighth
            state_r <= ST_CONV;
            count_r <= CNT_RESET;
          end
        end
        ST_CONV: begin
          // In internal-clock mode a new start bit restarts, since a fresh byte precedes each conversion
          if (conv_done) begin
            state_r <= ST_IDLE;
          end else if (!cs_n_s && sclk_rise && din_s && !clock_source_select) begin
            shift_r <= {{(BYTE_W-1){1'b0}}, 1'b1};
            count_r <= 4'h1;
            state_r <= ST_SHIFT;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          count_r <= CNT_RESET;
        end
      endcase
    end
  end

  // Latches the decoded fields when the byte completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {chan_select_msb, chan_select_mid, chan_select_lsb} <= RESET_CFG;
      polarity_select <= 1'b0;
      input_config_select <= 1'b0;
      power_state_select <= 1'b0;
      clock_source_select <= 1'b0;
      twos_complement <= 1'b0;
    end else if (state_r == ST_SHIFT && sclk_fall && count_r == BITS_IN_BYTE) begin
      // RULE_02 channel field
      chan_select_msb <= shift_r[POS_SEL_MSB];
      chan_select_mid <= shift_r[POS_SEL_MID];
      chan_select_lsb <= shift_r[POS_SEL_LSB];
      // RULE_03 polarity bit
      polarity_select <= shift_r[POS_POLARITY];
      // RULE_20 coding follows polarity
      twos_complement <= ~shift_r[POS_POLARITY];
      // RULE_04 input configuration
      input_config_select <= shift_r[POS_INPUT_CFG];
      // RULE_05 power state
      power_state_select <= shift_r[POS_POWER];
      // RULE_06 clock source
      clock_source_select <= shift_r[POS_CLK_SRC];
    end
  end

  // Mux routing from the byte still in the shifter, ready before hold
  assign {pos_nxt, neg_nxt} = route_inputs(shift_r[POS_SEL_MSB:POS_SEL_LSB],
                                           shift_r[POS_INPUT_CFG], four_inputs);

  // At the sixth bit the select, polarity and input-config bits are in, two places lower
  assign trk_pos = pos_of(shift_r[POS_SEL_MSB-TRACK_LAG:POS_SEL_LSB-TRACK_LAG], four_inputs);

  // Track/hold switch and multiplexer sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tracking <= 1'b0;
      hold_capacitor <= 1'b0;
      conv_start <= 1'b0;
      conv_busy <= 1'b0;
      pos_channel <= CH_WIDTH_ZERO;
      neg_channel <= NEG_IS_COM;
    end else begin
      conv_start <= 1'b0;
      if (state_r == ST_SHIFT && sclk_fall && count_r == TRACK_AFTER_BITS) begin
        // RULE_07 track after sixth
        tracking <= 1'b1;
        hold_capacitor <= 1'b0;
        pos_channel <= trk_pos;
      end
      if (state_r == ST_SHIFT && sclk_fall && count_r == BITS_IN_BYTE) begin
        // RULE_08 hold after eighth
        tracking <= 1'b0;
        hold_capacitor <= 1'b1;
        // RULE_09 negative node routing
        neg_channel <= neg_nxt;
        pos_channel <= pos_nxt; // Refresh from the complete byte
        conv_start <= 1'b1;
        conv_busy <= 1'b1;
      end else if (state_r == ST_CONV && conv_done) begin
        // RULE_10 back to positive input
        hold_capacitor <= 1'b0;
        tracking <= 1'b1;
        conv_busy <= 1'b0;
      end
    end
  end

  // Flags a zero result from a negative differential unipolar input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_invalid <= 1'b0;
    end else if (state_r == ST_CONV && conv_done) begin
      // RULE_14 zero code invalid
      result_invalid <= conv_result_zero & ~input_config_select & polarity_select;
    end else if (conv_start) begin
      result_invalid <= 1'b0;
    end
  end
endmodule

// *** verification/spi_host_model.sv ***
// Behavioural serial host that shifts control bytes into the decoder
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  // Idle bus: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // one byte per conversion, long track phase
  task automatic send(input logic [7:0] b, input int lead);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < lead + 8; i++) begin
      din = (i < lead) ? 1'b0 : b[7 - (i - lead)];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      if (i == lead + 5) repeat (12) @(negedge clk); // Stretch so tracking exceeds 1 us
    end
    din = ~din; // Released line must not look held
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
  endtask
  // Frame cut after n ones: select released mid-byte
  task automatic cut(input int n);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

// *** verification/adc_decoder_properties.sv ***
// Port assertions for the control-byte decoder
`timescale 1ns/1ps
module adc_decoder_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic four_inputs,
  input wire logic conv_done,
  input wire logic conv_result_zero,
  input wire logic chan_select_msb,
  input wire logic chan_select_mid,
  input wire logic chan_select_lsb,
  input wire logic polarity_select,
  input wire logic input_config_select,
  input wire logic tracking,
  input wire logic hold_capacitor,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic twos_complement,
  input wire logic [2:0] pos_channel,
  input wire logic [3:0] neg_channel,
  input wire logic result_invalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Sample held while converting, then released
  sequence s_sample;
    hold_capacitor && conv_busy && !tracking;
  endsequence
  sequence s_release;
    !hold_capacitor && !conv_busy && tracking;
  endsequence
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_hold_entry: assert property (conv_start |-> s_sample)
    else $error("no hold at start");
  a_hold_release: assert property (conv_done && conv_busy |=> s_release)
    else $error("hold not released");
  a_track_excl: assert property (!(tracking && hold_capacitor))
    else $error("track and hold together");
  a_coding_mode: assert property (conv_start |-> twos_complement != polarity_select)
    else $error("result coding wrong");
  a_pos_route: assert property (conv_start |-> pos_channel ==
    (four_inputs ? {1'b0, chan_select_mid, chan_select_msb}
                 : {chan_select_mid, chan_select_lsb, chan_select_msb}))
    else $error("positive input wrong");
  a_neg_route: assert property (conv_start |-> neg_channel ==
    (input_config_select ? 4'h8 : {1'b0, pos_channel ^ 3'h1}))
    else $error("negative input wrong");
  a_invalid_set: assert property (conv_done && conv_busy |=> result_invalid ==
    $past(!input_config_select && polarity_select && conv_result_zero))
    else $error("invalid flag wrong");
endmodule
bind adc_control_byte_decoder adc_decoder_properties adc_decoder_properties_inst (.*);

// *** verification/adc_control_byte_decoder_test.sv ***
// Random and corner control bytes through the decoder
`timescale 1ns/1ps
module adc_control_byte_decoder_test;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, four_inputs = 1'b0, conv_done = 1'b0, conv_result_zero = 1'b0;
  logic cs_n, sclk, din, chan_select_msb, chan_select_mid, chan_select_lsb, polarity_select;
  logic input_config_select, power_state_select, clock_source_select, tracking;
  logic hold_capacitor, conv_start, conv_busy, twos_complement, result_invalid, got_start, z;
  logic [2:0] pos_channel, ep;
  logic [3:0] neg_channel;
  logic [31:0] lfsr = 32'hb9e4;
  logic [7:0] b;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  spi_host_model spi_host_model_inst (.clk, .cs_n, .sclk, .din);
  adc_control_byte_decoder adc_control_byte_decoder_inst (.clk, .rst, .cs_n, .sclk, .din,
    .four_inputs, .conv_done, .conv_result_zero, .chan_select_msb, .chan_select_mid,
    .chan_select_lsb, .polarity_select, .input_config_select, .power_state_select,
    .clock_source_select, .tracking, .hold_capacitor, .conv_start, .conv_busy,
    .twos_complement, .pos_channel, .neg_channel, .result_invalid);
  always #25 clk = ~clk;
  // Pseudo-random source, fixed start for repeatable runs
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard and catcher for the one-cycle start pulse
  always @(posedge clk) begin
    cycles++;
    if (conv_start === 1'b1) got_start <= 1'b1;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Main sequence: all-ones and minimal bytes first, then random ones
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check({hold_capacitor, tracking, conv_busy, result_invalid, neg_channel}, 8'h08);
    for (int t = 0; t < 14; t++) begin
      lfsr = step(lfsr);
      b = (t == 0) ? 8'hff : (t == 1) ? 8'h80 : {1'b1, lfsr[6:0]};
      four_inputs = lfsr[9];
      z = lfsr[10] | (t == 2);
      // Internal-mode conversion left running, then restarted by the next byte
      if (t == 3) spi_host_model_inst.send(8'h8a, 0);
      got_start = 1'b0;
      spi_host_model_inst.send(b, t % 3);
      ep = four_inputs ? {1'b0, b[5], b[6]} : {b[5], b[4], b[6]};
      check({6'h0, result_invalid, got_start}, 8'h01);
      check({1'b1, chan_select_msb, chan_select_mid, chan_select_lsb, polarity_select,
        input_config_select, power_state_select, clock_source_select}, b);
      check({hold_capacitor, neg_channel, pos_channel},
        {1'b1, b[2] ? 4'h8 : {1'b0, ep ^ 3'h1}, ep});
      check({7'h0, twos_complement}, {7'h0, !b[3]});
      @(negedge clk);
      conv_done = 1'b1;
      conv_result_zero = z;
      @(negedge clk);
      conv_done = 1'b0;
      repeat (2) @(negedge clk);
      check({4'h0, tracking, hold_capacitor, conv_busy, result_invalid},
        {4'h0, 3'b100, !b[2] & b[3] & z});
      $display("test %0d byte %h done", t, b);
    end
    // Cut frame: no conversion, fields keep the last byte
    got_start = 1'b0;
    spi_host_model_inst.cut(5);
    check({7'h0, got_start}, 8'h00);
    check({1'b1, chan_select_msb, chan_select_mid, chan_select_lsb, polarity_select,
      input_config_select, power_state_select, clock_source_select}, b);
    $display("test cut frame done");
    test_done();
  end
endmodule
